// ==== core/urc_baud_gen.sv ====
`timescale 1ns/1ps

module urc_baud_gen import urc_pkg::*; #(
   parameter int DIV_W = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Rate selection.
   input wire logic [DIV_W-1:0] divisor,
   // Sampling tick.
   output logic tick
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic tick;
   } urc_baud_st_t;

   urc_baud_st_t s_r;
   urc_baud_st_t s_nxt;

   // Count down the divisor and pulse once per pass; a zero divisor halts it.
   // A count left over from a larger divisor is cut short, so a raised rate applies at once.
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (divisor == '0) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt == '0 || s_r.cnt >= divisor) begin
         s_nxt.cnt = divisor - 1'b1;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

   // Each tick reloads the counter with one less than the divisor.
   a_tick_reload: assert property (@(posedge clk) disable iff (sys_rst)
      tick |-> s_r.cnt == DIV_W'($past(divisor) - 1'b1))
      else $error("tick period does not follow the divisor");

   // A zero divisor produces no ticks.
   a_zero_halts: assert property (@(posedge clk) disable iff (sys_rst)
      (divisor == '0) |=> !tick)
      else $error("tick seen with zero divisor");

endmodule

// ==== core/urc_core.sv ====
`timescale 1ns/1ps
`include "urc_defs.svh"


module urc_core import urc_pkg::*; #(
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Host register port.
   input wire urc_host_req_t host_req,
   output logic [7:0] host_rdata,
   // Serial line.
   input wire logic rxd,
   output logic txd,
   // Status toward the host.
   output logic irq,
   output logic rx_err
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   // -----------------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] line_control;
      logic [7:0] ier;
      logic [7:0] dll;
      logic [7:0] dlm;
      logic fifo_en;
      logic [1:0] trig;
      logic [DEPTH-1:0][7:0] txq;
      logic [DEPTH-1:0][7:0] rxq;
      logic [AW-1:0] tx_wp;
      logic [AW-1:0] tx_rp;
      logic [AW-1:0] rx_wp;
      logic [AW-1:0] rx_rp;
      logic [CW-1:0] tx_cnt;
      logic [CW-1:0] rx_cnt;
      urc_tx_state_t tx_st;
      logic [3:0] tx_tick;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic tx_second;
      urc_rx_state_t rx_st;
      logic [3:0] rx_tick;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_bad;
      logic [7:0] rdata;
      logic txd;
      logic irq;
      logic rx_err;
   } urc_core_st_t;

   urc_core_st_t s_r;
   urc_core_st_t s_nxt;
   urc_line_cfg_t cfg;
   logic bank;
   logic tick;
   logic [CW-1:0] cap;
   logic [3:0] nbits;

   // Line settings decoded from the control byte.
   assign cfg = urc_line_cfg_t'(s_r.line_control);
   assign bank = s_r.line_control[`URC_LCR_BANK];
   assign nbits = urc_data_bits(cfg.wlen);
   // With the FIFOs off each direction holds a single character.
   assign cap = s_r.fifo_en ? CW'(DEPTH) : CW'(1);

   // -----------------------------------------------------------------------------
   // Rate generator
   // -----------------------------------------------------------------------------
   urc_baud_gen #(
      .DIV_W(16)
   ) u_baud (
      .clk(clk),
      .sys_rst(sys_rst),
      .divisor({s_r.dlm, s_r.dll}),
      .tick(tick)
   );

   // -----------------------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------------------
   always_comb begin
      logic tx_push;
      logic tx_pop;
      logic rx_push;
      logic rx_pop;
      logic line;
      logic [3:0] lvl;
      logic [7:0] rx_data;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      line = 1'b1;
      lvl = 4'h1;
      rx_data = s_r.rx_sh >> (4'h8 - nbits);
      s_nxt = s_r;
      s_nxt.rx_err = 1'b0;

      // Host writes to the data and enable offsets land in the bank that the control byte selects.
      if (host_req.wr) begin
         unique case (host_req.addr)
            `URC_OFF_DATA: begin
               if (bank) begin
                  s_nxt.dll = host_req.wdata;
               end else if (s_r.tx_cnt < cap) begin
                  tx_push = 1'b1;
               end
            end
            `URC_OFF_IER: begin
               if (bank) begin
                  s_nxt.dlm = host_req.wdata;
               end else begin
                  s_nxt.ier = {4'h0, host_req.wdata[`URC_IER_MS:`URC_IER_RDA]};
               end
            end
            `URC_OFF_FCR: begin
               s_nxt.fifo_en = host_req.wdata[`URC_FCR_EN];
               s_nxt.trig = host_req.wdata[`URC_FCR_TRIG_HI:`URC_FCR_TRIG_LO];
            end
            `URC_OFF_LCR: begin
               s_nxt.line_control = host_req.wdata;
            end
            default: begin
            end
         endcase
      end

      // Host reads; the receive buffer read also takes the character out.
      if (host_req.rd) begin
         unique case (host_req.addr)
            `URC_OFF_DATA: begin
               if (bank) begin
                  s_nxt.rdata = s_r.dll;
               end else begin
                  s_nxt.rdata = s_r.rxq[s_r.rx_rp];
                  rx_pop = (s_r.rx_cnt != '0);
               end
            end
            `URC_OFF_IER: begin
               s_nxt.rdata = bank ? s_r.dlm : s_r.ier;
            end
            `URC_OFF_LCR: begin
               s_nxt.rdata = s_r.line_control;
            end
            default: begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end

      // Transmit engine: start bit, data least significant first, parity, stop.
      if (s_r.tx_st != TX_IDLE && tick) begin
         s_nxt.tx_tick = s_r.tx_tick + 4'h1;
      end
      unique case (s_r.tx_st)
         TX_IDLE: begin
            // Starting on a tick keeps the start bit a full sixteen ticks long.
            if (s_r.tx_cnt != '0 && tick) begin
               tx_pop = 1'b1;
               s_nxt.tx_sh = s_r.txq[s_r.tx_rp];
               s_nxt.tx_par = urc_parity(s_r.txq[s_r.tx_rp], cfg);
               s_nxt.tx_st = TX_START;
               s_nxt.tx_tick = 4'h0;
            end
         end
         TX_START: begin
            line = 1'b0;
            if (tick && s_r.tx_tick == `URC_LAST_TICK) begin
               s_nxt.tx_st = TX_DATA;
               s_nxt.tx_bit = 3'h0;
            end
         end
         TX_DATA: begin
            line = s_r.tx_sh[0];
            if (tick && s_r.tx_tick == `URC_LAST_TICK) begin
               s_nxt.tx_sh = s_r.tx_sh >> 1;
               s_nxt.tx_bit = s_r.tx_bit + 3'h1;
               s_nxt.tx_second = 1'b0;
               if (s_r.tx_bit == 3'(nbits - 4'h1)) begin
                  s_nxt.tx_st = cfg.par_en ? TX_PAR : TX_STOP;
               end
            end
         end
         TX_PAR: begin
            line = s_r.tx_par;
            if (tick && s_r.tx_tick == `URC_LAST_TICK) begin
               s_nxt.tx_st = TX_STOP;
            end
         end
         TX_STOP: begin
            if (tick && s_r.tx_tick == `URC_LAST_TICK) begin
               if (cfg.two_stop && !s_r.tx_second) begin
                  s_nxt.tx_second = 1'b1;
               end else begin
                  s_nxt.tx_st = TX_IDLE;
               end
            end
         end
         default: begin
            s_nxt.tx_st = TX_IDLE;
         end
      endcase
      // Break overrides whatever the engine is sending.
      s_nxt.txd = cfg.brk ? 1'b0 : line;

      // Receive engine: confirm the start bit at mid-bit, then sample each bit centre.
      if (s_r.rx_st != RX_IDLE && tick) begin
         s_nxt.rx_tick = s_r.rx_tick + 4'h1;
      end
      unique case (s_r.rx_st)
         RX_IDLE: begin
            if (!rxd) begin
               s_nxt.rx_st = RX_START;
               s_nxt.rx_tick = 4'h0;
            end
         end
         RX_START: begin
            if (tick && s_r.rx_tick == `URC_MID_TICK) begin
               s_nxt.rx_tick = 4'h0;
               s_nxt.rx_bit = 3'h0;
               s_nxt.rx_bad = 1'b0;
               s_nxt.rx_st = rxd ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (tick && s_r.rx_tick == `URC_LAST_TICK) begin
               s_nxt.rx_sh = {rxd, s_r.rx_sh[7:1]};
               s_nxt.rx_bit = s_r.rx_bit + 3'h1;
               if (s_r.rx_bit == 3'(nbits - 4'h1)) begin
                  s_nxt.rx_st = cfg.par_en ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (tick && s_r.rx_tick == `URC_LAST_TICK) begin
               s_nxt.rx_bad = (rxd != urc_parity(rx_data, cfg));
               s_nxt.rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (tick && s_r.rx_tick == `URC_LAST_TICK) begin
               s_nxt.rx_st = RX_IDLE;
               s_nxt.rx_err = s_r.rx_bad || !rxd || (s_r.rx_cnt >= cap);
               rx_push = (s_r.rx_cnt < cap);
            end
         end
         default: begin
            s_nxt.rx_st = RX_IDLE;
         end
      endcase

      // Queue bookkeeping for both directions.
      if (tx_push) begin
         s_nxt.txq[s_r.tx_wp] = host_req.wdata;
         s_nxt.tx_wp = s_r.tx_wp + 1'b1;
      end
      if (tx_pop) begin
         s_nxt.tx_rp = s_r.tx_rp + 1'b1;
      end
      s_nxt.tx_cnt = s_r.tx_cnt + CW'(tx_push) - CW'(tx_pop);
      if (rx_push) begin
         s_nxt.rxq[s_r.rx_wp] = rx_data;
         s_nxt.rx_wp = s_r.rx_wp + 1'b1;
      end
      if (rx_pop) begin
         s_nxt.rx_rp = s_r.rx_rp + 1'b1;
      end
      s_nxt.rx_cnt = s_r.rx_cnt + CW'(rx_push) - CW'(rx_pop);

      // Clear strobes act on this write only; a change of FIFO mode empties both.
      if (host_req.wr && host_req.addr == `URC_OFF_FCR) begin
         if (host_req.wdata[`URC_FCR_RXCLR] || host_req.wdata[`URC_FCR_EN] != s_r.fifo_en) begin
            s_nxt.rx_wp = '0;
            s_nxt.rx_rp = '0;
            s_nxt.rx_cnt = '0;
         end
         if (host_req.wdata[`URC_FCR_TXCLR] || host_req.wdata[`URC_FCR_EN] != s_r.fifo_en) begin
            s_nxt.tx_wp = '0;
            s_nxt.tx_rp = '0;
            s_nxt.tx_cnt = '0;
         end
      end

      // Interrupt request from the enabled data conditions.
      if (s_nxt.fifo_en) begin
         lvl = urc_trig_level(s_nxt.trig);
      end
      s_nxt.irq = (s_nxt.ier[`URC_IER_RDA] && s_nxt.rx_cnt >= CW'(lvl)) ||
                  (s_nxt.ier[`URC_IER_THRE] && s_nxt.tx_cnt == '0);
   end

   // -----------------------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.line_control <= `URC_LCR_RST;
         s_r.ier <= `URC_IER_RST;
         s_r.dll <= `URC_DLL_RST;
         s_r.dlm <= `URC_DLM_RST;
         s_r.txd <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign host_rdata = s_r.rdata;
   assign txd = s_r.txd;
   assign irq = s_r.irq;
   assign rx_err = s_r.rx_err;

   // -----------------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic [3:0] lvl_now;
   assign lvl_now = s_r.fifo_en ? urc_trig_level(s_r.trig) : 4'h1;

   sequence tx_bit_end;
      tick && s_r.tx_tick == `URC_LAST_TICK;
   endsequence

   sequence first_stop_end;
      s_r.tx_st == TX_STOP && !s_r.tx_second && cfg.two_stop ##0 tx_bit_end;
   endsequence

   a_break_line_low: assert property (cfg.brk |=> !txd)
      else $error("break set but line not low");

   a_divisor_low_write: assert property (
      host_req.wr && host_req.addr == `URC_OFF_DATA && bank |=> s_r.dll == $past(host_req.wdata))
      else $error("divisor low byte not loaded");

   a_holding_push: assert property (
      host_req.wr && host_req.addr == `URC_OFF_DATA && !bank && s_r.tx_cnt == '0
      |=> s_r.tx_cnt == CW'(1))
      else $error("holding write not queued");

   a_buffer_read: assert property (
      host_req.rd && host_req.addr == `URC_OFF_DATA && !bank |=> host_rdata == $past(s_r.rxq[s_r.rx_rp]))
      else $error("receive buffer read returned wrong byte");

   a_rx_fifo_clear: assert property (
      host_req.wr && host_req.addr == `URC_OFF_FCR && host_req.wdata[`URC_FCR_RXCLR] |=> s_r.rx_cnt == '0)
      else $error("receive fifo not emptied");

   a_tx_clear_keeps: assert property (
      host_req.wr && host_req.addr == `URC_OFF_FCR && host_req.wdata[`URC_FCR_TXCLR] && s_r.tx_st != TX_IDLE
      && !(tick && s_r.tx_tick == `URC_LAST_TICK)
      |=> s_r.tx_cnt == '0 && s_r.tx_st == $past(s_r.tx_st) && s_r.tx_sh == $past(s_r.tx_sh))
      else $error("transmit clear disturbed the shift register");

   a_trigger_irq: assert property (
      s_r.ier[`URC_IER_RDA] && s_r.rx_cnt >= CW'(lvl_now) |-> irq)
      else $error("trigger level reached without request");

   a_start_to_data: assert property (
      s_r.tx_st == TX_START ##0 tx_bit_end |=> s_r.tx_st == TX_DATA ##0 txd == 1'b0 || cfg.brk)
      else $error("start bit did not last one bit period");

   a_second_stop: assert property (first_stop_end |=> s_r.tx_st == TX_STOP)
      else $error("second stop bit missing");

   a_last_data_bit: assert property (
      s_r.tx_st == TX_DATA && s_r.tx_bit == 3'(nbits - 4'h1) && !cfg.par_en ##0 tx_bit_end
      |=> s_r.tx_st == TX_STOP)
      else $error("character length not honoured");

endmodule

// ==== core/urc_defs.svh ====
`ifndef URC_DEFS_SVH
`define URC_DEFS_SVH

// -----------------------------------------------------------------------------
// Register offsets from the port base
// -----------------------------------------------------------------------------
`define URC_OFF_DATA 3'h0
`define URC_OFF_IER 3'h1
`define URC_OFF_FCR 3'h2
`define URC_OFF_LCR 3'h3

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define URC_LCR_BREAK 6
`define URC_LCR_BANK 7
`define URC_IER_RDA 0
`define URC_IER_THRE 1
`define URC_IER_RLS 2
`define URC_IER_MS 3
`define URC_FCR_EN 0
`define URC_FCR_RXCLR 1
`define URC_FCR_TXCLR 2
`define URC_FCR_TRIG_LO 6
`define URC_FCR_TRIG_HI 7

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define URC_LCR_RST 8'h03
`define URC_IER_RST 8'h00
`define URC_DLL_RST 8'h0C
`define URC_DLM_RST 8'h00

// -----------------------------------------------------------------------------
// Timing counts and trigger levels
// -----------------------------------------------------------------------------
`define URC_LAST_TICK 4'hF
`define URC_MID_TICK 4'h7
`define URC_TRIG_00 4'h1
`define URC_TRIG_01 4'h4
`define URC_TRIG_10 4'h8
`define URC_TRIG_11 4'hE

`endif

// ==== core/urc_pkg.sv ====
`include "urc_defs.svh"

package urc_pkg;

   // -----------------------------------------------------------------------------
   // Host side request and line settings
   // -----------------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } urc_host_req_t;

   // Line control byte, most significant field first.
   typedef struct packed {
      logic bank;
      logic brk;
      logic stick;
      logic even;
      logic par_en;
      logic two_stop;
      logic [1:0] wlen;
   } urc_line_cfg_t;

   // -----------------------------------------------------------------------------
   // Engine states
   // -----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100
   } urc_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100
   } urc_rx_state_t;

   // Number of data bits for a length code.
   function automatic logic [3:0] urc_data_bits(input logic [1:0] wlen);
      urc_data_bits = 4'h5 + {2'b00, wlen};
   endfunction

   // Receive trigger level for a threshold code.
   function automatic logic [3:0] urc_trig_level(input logic [1:0] code);
      case (code)
         2'b00: urc_trig_level = `URC_TRIG_00;
         2'b01: urc_trig_level = `URC_TRIG_01;
         2'b10: urc_trig_level = `URC_TRIG_10;
         default: urc_trig_level = `URC_TRIG_11;
      endcase
   endfunction

   // Parity bit for a character under the given line settings.
   function automatic logic urc_parity(input logic [7:0] d, input urc_line_cfg_t c);
      logic x;
      x = ^(d & (8'hFF >> (2'h3 - c.wlen)));
      if (c.stick) begin
         urc_parity = ~c.even;
      end else if (c.even) begin
         urc_parity = x;
      end else begin
         urc_parity = ~x;
      end
   endfunction

endpackage

// ==== tb/urc_core_tb.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Register port testbench
// ------------------------------------------------------------
module urc_core_tb import urc_pkg::*;;
   logic clk;
   logic sys_rst;
   urc_host_req_t host_req;
   logic [7:0] host_rdata;
   logic rxd;
   logic txd;
   logic irq;
   logic rx_err;
   logic [3:0] nbits;
   logic par_en;
   logic [7:0] bit_len;
   logic [7:0] got;
   logic got_par;
   logic got_stop;
   int frames;
   int mismatches;
   int checked;
   int errs;

   urc_core #(.DEPTH(4)) dut (.clk(clk), .sys_rst(sys_rst), .host_req(host_req), .host_rdata(host_rdata),
      .rxd(rxd), .txd(txd), .irq(irq), .rx_err(rx_err));
   urc_remote remote (.clk(clk), .txd(txd), .rxd(rxd), .nbits(nbits), .par_en(par_en), .bit_len(bit_len),
      .got(got), .got_par(got_par), .got_stop(got_stop), .frames(frames));

   // Clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Error pulses from the receiver are counted.
   always @(negedge clk) begin
      if (rx_err === 1'b1) begin
         errs <= errs + 1;
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checked++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         mismatches++;
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      host_req.addr = a;
      host_req.wdata = d;
      host_req.wr = 1'b1;
      @(negedge clk);
      host_req.wr = 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      host_req.addr = a;
      host_req.rd = 1'b1;
      @(negedge clk);
      host_req.rd = 1'b0;
      chk(what, exp, host_rdata);
   endtask

   // Waits for the remote to finish a frame, bounded.
   task automatic wait_frame(input int f0);
      int n;
      n = 0;
      while (frames == f0 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      if (frames == f0) begin
         chk("frame count", 8'h01, 8'h00);
      end
   endtask

   task automatic set_div(input logic [15:0] dv);
      wr(3'h3, 8'h83);
      wr(3'h0, dv[7:0]);
      wr(3'h1, dv[15:8]);
      wr(3'h3, 8'h03);
      bit_len = 8'(dv * 16);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd(3'h3, 8'h03, "line control");
      rd(3'h1, 8'h00, "interrupt enable");
      rd(3'h2, 8'h00, "fifo control read");
      rd(3'h5, 8'h00, "unmapped offset");
      wr(3'h7, 8'hFF);
      rd(3'h3, 8'h03, "line control after stray write");
      wr(3'h1, 8'h0F);
      rd(3'h1, 8'h0F, "four enables");
      wr(3'h3, 8'h83);
      rd(3'h0, 8'h0C, "divisor low");
      rd(3'h1, 8'h00, "divisor high");
      wr(3'h1, 8'h12);
      rd(3'h1, 8'h12, "divisor high written");
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      rd(3'h0, 8'h00, "divisor low written");
      wr(3'h3, 8'h03);
      rd(3'h1, 8'h0F, "enables kept apart");
      wr(3'h1, 8'h00);
      set_div(16'h0001);
   endtask

   task automatic tx_one(input logic [7:0] line_control, input logic [3:0] nb, input logic [7:0] d,
         input logic [7:0] exp_d, input logic exp_p);
      int f0;
      wr(3'h3, line_control);
      nbits = nb;
      par_en = line_control[3];
      f0 = frames;
      wr(3'h0, d);
      wait_frame(f0);
      chk("sent data", exp_d, got);
      chk("sent parity", {7'h00, exp_p}, {7'h00, got_par & par_en});
      chk("sent stop", 8'h01, {7'h00, got_stop});
   endtask

   task automatic t_rate(input logic [15:0] dv);
      int n;
      int w;
      int f0;
      set_div(dv);
      f0 = frames;
      wr(3'h0, 8'h01);
      n = 0;
      w = 0;
      while (txd !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      while (txd === 1'b0 && w < 255) begin
         @(negedge clk);
         w++;
      end
      chk("start bit width", 8'(dv * 16), 8'(w));
      wait_frame(f0);
   endtask

   task automatic t_break();
      int f0;
      f0 = frames;
      wr(3'h3, 8'h43);
      repeat (3) @(negedge clk);
      chk("break level", 8'h00, {7'h00, txd});
      wr(3'h3, 8'h03);
      repeat (3) @(negedge clk);
      chk("line after break", 8'h01, {7'h00, txd});
      wait_frame(f0);
   endtask

   task automatic t_rx();
      remote.send(8'h3C, 1'b0, 1'b1);
      rd(3'h0, 8'h3C, "received byte");
      wr(3'h2, 8'h41);
      wr(3'h1, 8'h01);
      remote.send(8'h11, 1'b0, 1'b1);
      remote.send(8'h22, 1'b0, 1'b1);
      remote.send(8'h33, 1'b0, 1'b1);
      chk("irq below trigger", 8'h00, {7'h00, irq});
      remote.send(8'h44, 1'b0, 1'b1);
      chk("irq at trigger", 8'h01, {7'h00, irq});
      rd(3'h0, 8'h11, "fifo head");
      repeat (2) @(negedge clk);
      chk("irq after pop", 8'h00, {7'h00, irq});
      wr(3'h2, 8'h43);
      wr(3'h2, 8'h01);
      remote.send(8'h55, 1'b0, 1'b1);
      chk("irq trigger one", 8'h01, {7'h00, irq});
      rd(3'h0, 8'h55, "byte after clear");
      repeat (2) @(negedge clk);
      chk("irq when empty", 8'h00, {7'h00, irq});
      wr(3'h1, 8'h02);
      repeat (3) @(negedge clk);
      chk("irq tx empty", 8'h01, {7'h00, irq});
      wr(3'h1, 8'h00);
      repeat (3) @(negedge clk);
      chk("irq masked", 8'h00, {7'h00, irq});
   endtask

   // A transmit clear in mid-character drops the queued byte but finishes the one on the line.
   task automatic t_tx_clear();
      int f0;
      f0 = frames;
      wr(3'h0, 8'h5A);
      wr(3'h0, 8'h6B);
      repeat (4) @(negedge clk);
      wr(3'h2, 8'h05);
      wait_frame(f0);
      chk("sent before clear", 8'h5A, got);
      repeat (200) @(negedge clk);
      chk("frames after clear", 8'(f0 + 1), 8'(frames));
   endtask

   task automatic t_parity_err();
      int e0;
      wr(3'h3, 8'h1B);
      par_en = 1'b1;
      e0 = errs;
      remote.send(8'hA5, 1'b1, 1'b1);
      chk("error pulses", 8'(e0 + 1), 8'(errs));
      remote.send(8'hA5, 1'b0, 1'b1);
      chk("no error good parity", 8'(e0 + 1), 8'(errs));
   endtask

   // Watchdog for a hung run.
   initial begin
      #1000000;
      mismatches++;
      close_out();
   end

   // Main sequence.
   initial begin
      sys_rst = 1'b1;
      host_req = '0;
      nbits = 4'h8;
      par_en = 1'b0;
      bit_len = 8'hC0;
      mismatches = 0;
      checked = 0;
      errs = 0;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      t_regs();
      tx_one(8'h03, 4'h8, 8'hA5, 8'hA5, 1'b0);
      tx_one(8'h1A, 4'h7, 8'hD5, 8'h55, 1'b0);
      tx_one(8'h0A, 4'h7, 8'hD5, 8'h55, 1'b1);
      tx_one(8'h0C, 4'h5, 8'h13, 8'h13, 1'b0);
      tx_one(8'h3B, 4'h8, 8'h01, 8'h01, 1'b0);
      wr(3'h3, 8'h03);
      par_en = 1'b0;
      nbits = 4'h8;
      t_rate(16'h0002);
      t_rate(16'h0001);
      t_break();
      t_rx();
      t_tx_clear();
      t_parity_err();
      close_out();
   end
endmodule

// ==== tb/urc_remote.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Remote serial device on the far end of the line
// ------------------------------------------------------------
module urc_remote import urc_pkg::*; (
   // Clock.
   input wire logic clk,
   // Serial line, idle at the mark level.
   input wire logic txd,
   output logic rxd,
   // Frame format shared with the port.
   input wire logic [3:0] nbits,
   input wire logic par_en,
   input wire logic [7:0] bit_len,
   // Last frame heard.
   output logic [7:0] got,
   output logic got_par,
   output logic got_stop,
   output int frames
);
   // Receiver samples each bit at its middle, least significant bit first.
   initial begin
      rxd = 1'b1;
      got = 8'h00;
      got_par = 1'b0;
      got_stop = 1'b0;
      frames = 0;
      forever begin
         @(negedge clk iff txd === 1'b0);
         repeat (bit_len / 2) @(negedge clk);
         got = 8'h00;
         for (int i = 0; i < nbits; i++) begin
            repeat (bit_len) @(negedge clk);
            got[i] = txd;
         end
         if (par_en) begin
            repeat (bit_len) @(negedge clk);
            got_par = txd;
         end
         repeat (bit_len) @(negedge clk);
         got_stop = txd;
         frames++;
      end
   end

   // Sends one frame; parity and stop levels are chosen by the caller.
   task automatic send(input logic [7:0] d, input logic par, input logic stop);
      @(negedge clk);
      rxd = 1'b0;
      repeat (bit_len) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         rxd = d[i];
         repeat (bit_len) @(negedge clk);
      end
      if (par_en) begin
         rxd = par;
         repeat (bit_len) @(negedge clk);
      end
      rxd = stop;
      repeat (bit_len) @(negedge clk);
      rxd = 1'b1;
      repeat (bit_len) @(negedge clk);
   endtask
endmodule
